/* sfl_defines.svh */
// Purpose: Constants of the signaling and loopback sequencer.
// Assumes: 1 ms timebase from a 200 MHz clock.
// Notes:   Times are in ms, sized to the counter they meet.
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH
`define SF_CLK_NS        5
`define SF_MS_NS         1000000
`define SF_BRK_MIN_MS    8'h12
`define SF_CUT_LEAD_MS   8'h12
`define SF_BURST_MIN_MS  8'h32
`define SF_CUT_REL_MS    8'h7d
`define SF_HI_MS         9'h190
`define SF_GRD_HL_MS     8'he1
`define SF_GRD_LH_MS     8'h32
`define SF_BEF_MIN_MS    8'he1
`define SF_BEF_TAIL_MS   8'h32
`define SF_REL_MS        8'hfa
`define SF_LB_ACT_MS     12'h9c4
`define SF_LB_DEACT_MS   12'h4b0
`define SF_TMO4_MS       21'h03a980
`define SF_TMO20_MS      21'h124f80
`define SF_OFS_CTRL      8'h00
`define SF_OFS_STAT      8'h04
`define SF_CTRL_TMO20    0
`define SF_CTRL_RST      1'h0
`define SF_ST_RELAY      0
`define SF_ST_TONE_LB    1
`define SF_ST_EXT        2
`define SF_ST_MAN        3
`define SF_ST_TONE       4
`define SF_ST_HIGH       5
`define SF_ST_CUT        6
`define SF_ST_BEF        7
`define SF_ST_GUARD      8
`define SF_ST_LOOP       9
`define SF_ST_BUSY       10
`define SF_ST_W          11
`endif

/* sfl_pkg.sv */
// Purpose: Types of the signaling and loopback sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   State of the top module is one packed struct.
package sfl_pkg;
  typedef enum logic [2:0] {
    LB_IDLE,
    LB_ARM,
    LB_ARMED,
    LB_ACTIVE,
    LB_REL,
    LB_DONE
  } sfl_lb_t;

  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [17:0] tick_cnt;
    logic        tick;
    logic [7:0]  brk_ms;
    logic [7:0]  off_ms;
    logic [7:0]  tone_ms;
    logic [8:0]  hi_ms;
    logic        tx_tone;
    logic        tx_cut;
    logic [7:0]  rx_off_ms;
    logic [7:0]  grd_ms;
    logic [7:0]  bef_ms;
    logic        guard;
    logic        bef;
    logic        loop_sig;
    sfl_lb_t     lb_st;
    logic [11:0] lb_ms;
    logic [20:0] tmo_ms;
    logic        relay;
    logic        tone_on;
    logic        tone_high;
    logic        cut;
    logic        sleeve_oe;
    logic        tmo20;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sfl_state_t;
endpackage : sfl_pkg

/* sfl_ctrl.sv */
// Purpose: Signaling and loopback sequencer of an SF terminal repeater.
// Assumes: Pins are asynchronous; APB is on CLK.
// Notes:   All timing runs from one 1 ms tick.
// Overview of operation
// - Relay operates on loopback tone, grounded lead or closed switch.
// - Tone loopback ends on a second loopback tone or on timeout.
// - Lead loopback lasts while the lead stays grounded.
// - Switch loopback lasts until the switch is opened.
// - In loopback the relay loops receive output into transmit input.
// - In loopback every received SF signal is sent back to the facility.
// - Loop state drives path cut and tone; received tone drives loop output.
// - Each tone start sends high level for 400 ms, then low level.
// - Loop breaks under 18 ms send no tone.
// - Breaks of 18 to 50 ms become 50 ms tone bursts.
// - Breaks over 50 ms send tone as long as the break.
// - Transmit path opens 18 ms before tone starts.
// - Transmit path is restored 125 ms after off-hook.
// - Guard falls after 225 ms, rises after 50 ms.
// - Short tones keep the filter in for 225 ms, past the tone.
// - Long tones keep the filter in for tone plus 50 ms.
// - Loop output changes 250 ms after received tone ends.
// - Tone loopback needs 2.5 s of tone and starts on its removal.
// - In loopback 1.2 s of tone releases, while tone persists.
// - Timeout of 4 or 20 minutes applies to tone loopback only.
// - Sleeve output floats when idle and is grounded when busy.
`timescale 1ns/1ps
`include "sfl_defines.svh"
module sfl_ctrl #(
  parameter int TICK_CYCLES = `SF_MS_NS / `SF_CLK_NS
) (
  input  wire logic        CLK,             // 200 MHz clock
  input  wire logic        RSTN,            // Async reset, low
  input  wire logic        PSEL,            // APB select
  input  wire logic        PENABLE,         // APB access phase
  input  wire logic        PWRITE,          // APB write
  input  wire logic [7:0]  PADDR,           // APB byte address
  input  wire logic [31:0] PWDATA,          // APB write data
  output logic             PREADY,          // APB ready
  output logic             PSLVERR,         // APB error
  output logic [31:0]      PRDATA,          // APB read data
  input  wire logic        LOOP_OFFHOOK,    // Local loop closed
  input  wire logic        SF_TONE_DET,     // 2600 Hz detected
  input  wire logic        LB_TONE_DET,     // Loopback tone detected
  input  wire logic        EXT_LOOPBACK_N,  // Lead grounded, low
  input  wire logic        MAN_LOOPBACK_SW, // Switch closed, high
  output logic             TONE_ON,         // Oscillator gate
  output logic             TONE_HIGH,       // High tone level
  output logic             XMT_CUT,         // Transmit path open
  output logic             BAND_ELIM_FILTER,// Filter inserted
  output logic             GUARD,           // Receive guard
  output logic             LOOP_SIG,        // Loop signaling state
  output logic             LOOPBACK_RELAY,  // Relay energized
  output logic             SLEEVE_O,        // Sleeve drive value
  output logic             SLEEVE_OE        // Sleeve drive enable
);
  import sfl_pkg::*;

  sfl_state_t  r;
  sfl_state_t  n;
  logic        offhook;
  logic        sf_det;
  logic        lb_det;
  logic        ext_lb;
  logic        man_lb;
  logic        tone_lb;
  logic [20:0] tmo_lim;
  logic [31:0] stat_word;
  logic        addr_hit;

  assign offhook = r.s2[4];
  assign sf_det  = r.s2[3];
  assign lb_det  = r.s2[2];
  assign ext_lb  = r.s2[1];
  assign man_lb  = r.s2[0];
  assign tone_lb = (r.lb_st == LB_ACTIVE) || (r.lb_st == LB_REL);
  assign tmo_lim = r.tmo20 ? `SF_TMO20_MS : `SF_TMO4_MS;
  assign addr_hit = (PADDR == `SF_OFS_CTRL) ||
                    (PADDR == `SF_OFS_STAT);

  assign stat_word[`SF_ST_RELAY]   = r.relay;
  assign stat_word[`SF_ST_TONE_LB] = tone_lb;
  assign stat_word[`SF_ST_EXT]     = ext_lb;
  assign stat_word[`SF_ST_MAN]     = man_lb;
  assign stat_word[`SF_ST_TONE]    = r.tone_on;
  assign stat_word[`SF_ST_HIGH]    = r.tone_high;
  assign stat_word[`SF_ST_CUT]     = r.cut;
  assign stat_word[`SF_ST_BEF]     = r.bef;
  assign stat_word[`SF_ST_GUARD]   = r.guard;
  assign stat_word[`SF_ST_LOOP]    = r.loop_sig;
  assign stat_word[`SF_ST_BUSY]    = r.sleeve_oe;
  assign stat_word[31:`SF_ST_W]    = '0;

  always_comb begin
    n = r;
    // Two-stage synchronisers on every pin input
    n.s1 = {LOOP_OFFHOOK, SF_TONE_DET, LB_TONE_DET,
            ~EXT_LOOPBACK_N, MAN_LOOPBACK_SW};
    n.s2 = r.s1;

    // Millisecond timebase
    n.tick = 1'b0;
    if (r.tick_cnt == 18'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 18'h1;
    end

    if (r.tick) begin
      // Transmit side: break timing, burst length, path cut
      if (!offhook) begin
        n.off_ms = '0;
        n.tx_cut = 1'b1;
        if (r.brk_ms != '1) begin
          n.brk_ms = r.brk_ms + 8'h1;
        end
        // Tone waits out the cut lead; short breaks never get here
        if (!r.tx_tone && r.brk_ms == `SF_BRK_MIN_MS) begin
          n.tx_tone = 1'b1;
          n.tone_ms = '0;
        end
      end else begin
        n.brk_ms = '0;
        if (r.off_ms != '1) begin
          n.off_ms = r.off_ms + 8'h1;
        end
      end
      if (r.tx_tone) begin
        if (r.tone_ms != '1) begin
          n.tone_ms = r.tone_ms + 8'h1;
        end
        // End is delayed by the same lead so length tracks the break
        if (offhook && r.off_ms >= `SF_CUT_LEAD_MS &&
            r.tone_ms >= `SF_BURST_MIN_MS) begin
          n.tx_tone = 1'b0;
        end
      end
      if (offhook && !r.tx_tone &&
          r.off_ms >= `SF_CUT_REL_MS) begin
        n.tx_cut = 1'b0;
      end

      // High tone level window from each tone start
      if (r.tone_on && r.hi_ms != '1) begin
        n.hi_ms = r.hi_ms + 9'h1;
      end

      // Receive guard
      if (sf_det == r.guard) begin
        n.grd_ms = '0;
      end else begin
        if (r.grd_ms != '1) begin
          n.grd_ms = r.grd_ms + 8'h1;
        end
        if (r.guard && r.grd_ms >= `SF_GRD_HL_MS) begin
          n.guard  = 1'b0;
          n.grd_ms = '0;
        end
        if (!r.guard && r.grd_ms >= `SF_GRD_LH_MS) begin
          n.guard  = 1'b1;
          n.grd_ms = '0;
        end
      end

      // Filter insertion and loop signaling release
      if (sf_det) begin
        n.rx_off_ms = '0;
        n.loop_sig  = 1'b1;
        n.bef       = 1'b1;
        if (!r.bef) begin
          n.bef_ms = '0;
        end else if (r.bef_ms != '1) begin
          n.bef_ms = r.bef_ms + 8'h1;
        end
      end else begin
        if (r.rx_off_ms != '1) begin
          n.rx_off_ms = r.rx_off_ms + 8'h1;
        end
        if (r.bef && r.bef_ms != '1) begin
          n.bef_ms = r.bef_ms + 8'h1;
        end
        // Both bounds met: short tones end at the floor, long at tail
        if (r.bef && r.rx_off_ms >= `SF_BEF_TAIL_MS &&
            r.bef_ms >= `SF_BEF_MIN_MS) begin
          n.bef = 1'b0;
        end
        if (r.rx_off_ms >= `SF_REL_MS) begin
          n.loop_sig = 1'b0;
        end
      end

      // Tone loopback sequence
      case (r.lb_st)
        LB_IDLE: begin
          n.lb_ms = '0;
          if (lb_det) begin
            n.lb_st = LB_ARM;
          end
        end
        LB_ARM: begin
          if (!lb_det) begin
            n.lb_st = LB_IDLE;
          end else if (r.lb_ms >= `SF_LB_ACT_MS) begin
            n.lb_st = LB_ARMED;
          end else begin
            n.lb_ms = r.lb_ms + 12'h1;
          end
        end
        LB_ARMED: begin
          if (!lb_det) begin
            n.lb_st  = LB_ACTIVE;
            n.tmo_ms = '0;
            n.lb_ms  = '0;
          end
        end
        LB_ACTIVE: begin
          n.lb_ms  = '0;
          n.tmo_ms = r.tmo_ms + 21'h1;
          if (r.tmo_ms >= tmo_lim) begin
            n.lb_st = LB_IDLE;
          end else if (lb_det) begin
            n.lb_st = LB_REL;
          end
        end
        LB_REL: begin
          n.tmo_ms = r.tmo_ms + 21'h1;
          if (r.tmo_ms >= tmo_lim) begin
            n.lb_st = LB_DONE;
          end else if (!lb_det) begin
            n.lb_st = LB_ACTIVE;
          end else if (r.lb_ms >= `SF_LB_DEACT_MS) begin
            n.lb_st = LB_DONE;
          end else begin
            n.lb_ms = r.lb_ms + 12'h1;
          end
        end
        LB_DONE: begin
          // Releasing tone must go before it can arm again
          if (!lb_det) begin
            n.lb_st = LB_IDLE;
          end
        end
        default: begin
          n.lb_st = LB_IDLE;
        end
      endcase
    end

    // Relay: any source holds it
    n.relay = tone_lb || ext_lb || man_lb;
    // Loopback echoes received tone instead of loop tone
    n.tone_on = r.relay ? sf_det : r.tx_tone;
    if (!r.tone_on) begin
      n.hi_ms = '0;
    end
    // Level follows the gate in the same cycle, start and end alike
    n.tone_high = n.tone_on && (n.hi_ms < `SF_HI_MS);
    n.cut       = r.relay ? 1'b0 : r.tx_cut;
    n.sleeve_oe = offhook;

    // APB slave: answer in the access cycle after setup
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      n.pready  = 1'b1;
      n.pslverr = !addr_hit;
      n.prdata  = '0;
      if (!PWRITE && PADDR == `SF_OFS_CTRL) begin
        n.prdata[`SF_CTRL_TMO20] = r.tmo20;
      end
      if (!PWRITE && PADDR == `SF_OFS_STAT) begin
        n.prdata = stat_word;
      end
    end
    if (PSEL && PENABLE && r.pready && PWRITE &&
        PADDR == `SF_OFS_CTRL) begin
      n.tmo20 = PWDATA[`SF_CTRL_TMO20];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r           <= '0;
      r.lb_st     <= LB_IDLE;
      r.tmo20     <= `SF_CTRL_RST;
    end else begin
      r <= n;
    end
  end

  assign PREADY           = r.pready;
  assign PSLVERR          = r.pslverr;
  assign PRDATA           = r.prdata;
  assign TONE_ON          = r.tone_on;
  assign TONE_HIGH        = r.tone_high;
  assign XMT_CUT          = r.cut;
  assign BAND_ELIM_FILTER = r.bef;
  assign GUARD            = r.guard;
  assign LOOP_SIG         = r.loop_sig;
  assign LOOPBACK_RELAY   = r.relay;
  assign SLEEVE_O         = 1'b0;
  assign SLEEVE_OE        = r.sleeve_oe;
endmodule : sfl_ctrl

/* sfl_chk_sva.sv */
// Purpose: Port checker of the signaling sequencer.
// Assumes: TICK_CYCLES clocks make one ms.
// Notes:   Bound into every sfl_ctrl instance.
`timescale 1ns/1ps
module sfl_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic       CLK, RSTN, PSEL, PENABLE, PREADY, PSLVERR,
  input wire logic [7:0] PADDR,
  input wire logic       SF_TONE_DET, EXT_LOOPBACK_N, MAN_LOOPBACK_SW,
  input wire logic       TONE_ON, TONE_HIGH, XMT_CUT, BAND_ELIM_FILTER,
  input wire logic       GUARD, LOOPBACK_RELAY, SLEEVE_O, SLEEVE_OE
);
  localparam int RISE_MAX  = TICK_CYCLES + 6;
  localparam int CUT_LAG   = 13 * TICK_CYCLES;
  localparam int GRD_LAG   = 40 * TICK_CYCLES;
  localparam int BURST_MIN = 47 * TICK_CYCLES;
  logic [15:0] on_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Length of the current tone burst in clocks
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      on_cnt <= 16'h0;
    else
      on_cnt <= TONE_ON ? on_cnt + 16'h1 : 16'h0;
  end
  a_apb_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No ready after setup");
  a_unmapped_err: assert property (PSEL && !PENABLE && PADDR != 8'h00
    && PADDR != 8'h04 |=> PSLVERR) else $error("No error on bad address");
  a_high_gated: assert property (TONE_HIGH |-> TONE_ON)
    else $error("High level without tone");
  a_rise_high: assert property ($rose(TONE_ON) |-> TONE_HIGH)
    else $error("Tone start not at high level");
  a_cut_lead: assert property ($rose(TONE_ON) && !LOOPBACK_RELAY
    |-> $past(XMT_CUT, CUT_LAG)) else $error("Path not cut before tone");
  a_lead_relay: assert property (!EXT_LOOPBACK_N [*8]
    |=> LOOPBACK_RELAY) else $error("Lead does not hold relay");
  a_switch_relay: assert property (MAN_LOOPBACK_SW [*8]
    |=> LOOPBACK_RELAY) else $error("Switch does not hold relay");
  a_filter_in: assert property ($rose(SF_TONE_DET)
    |-> ##[1:RISE_MAX] BAND_ELIM_FILTER) else $error("Filter not inserted");
  a_guard_rise: assert property ($rose(GUARD)
    |-> $past(SF_TONE_DET, GRD_LAG)) else $error("Guard rose too early");
  a_sleeve_ground: assert property (SLEEVE_OE |-> !SLEEVE_O)
    else $error("Sleeve driven high");
  a_burst_min: assert property ($fell(TONE_ON) && !LOOPBACK_RELAY
    |-> $past(on_cnt) >= BURST_MIN) else $error("Tone burst too short");
  c_burst: cover property ($fell(TONE_ON));
  c_relay: cover property ($rose(LOOPBACK_RELAY));
  c_guard: cover property ($fell(GUARD));
endmodule : sfl_chk

bind sfl_ctrl sfl_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.CLK, .RSTN,
  .PSEL, .PENABLE, .PREADY, .PSLVERR, .PADDR, .SF_TONE_DET,
  .EXT_LOOPBACK_N, .MAN_LOOPBACK_SW, .TONE_ON, .TONE_HIGH, .XMT_CUT,
  .BAND_ELIM_FILTER, .GUARD, .LOOPBACK_RELAY, .SLEEVE_O, .SLEEVE_OE);

/* sfl_far.sv */
// Purpose: Loop, detector and sleeve side of the sequencer.
// Assumes: Levels change just after a rising CLK edge.
// Notes:   act bits: 0 break, 1 SF tone, 2 LB tone, 3 lead, 4 switch.
`timescale 1ns/1ps
module sfl_far (
  input  wire logic CLK,             // Clock
  input  wire logic SLEEVE_O,        // Sleeve drive value
  input  wire logic SLEEVE_OE,       // Sleeve drive enable
  output logic      LOOP_OFFHOOK,    // Loop closed
  output logic      SF_TONE_DET,     // SF tone heard
  output logic      LB_TONE_DET,     // Loopback tone heard
  output logic      EXT_LOOPBACK_N,  // Lead grounded, low
  output logic      MAN_LOOPBACK_SW, // Switch closed
  output logic      SLEEVE_LINE      // Resolved sleeve lead
);
  logic [4:0] act = 5'h0;
  assign LOOP_OFFHOOK    = !act[0];
  assign SF_TONE_DET     = act[1];
  assign LB_TONE_DET     = act[2];
  assign EXT_LOOPBACK_N  = !act[3]; // Ground lifted to release
  assign MAN_LOOPBACK_SW = act[4];
  // Open lead rests at the clamp level
  assign SLEEVE_LINE     = SLEEVE_OE ? SLEEVE_O : 1'b1;
  task automatic set(input int i, input logic v);
    @(posedge CLK);
    act[i] <= v;
  endtask : set
endmodule : sfl_far

/* sfl_ctrl_test.sv */
// Purpose: Self-checking bench of the signaling sequencer.
// Assumes: 4 clocks per ms in simulation.
// Notes:   Times below are in scaled ms.
`timescale 1ns/1ps
module sfl_ctrl_test;
  localparam int TC = 4;
  logic        CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, err, LOOP_OFFHOOK, SF_TONE_DET, LB_TONE_DET;
  logic        EXT_LOOPBACK_N, MAN_LOOPBACK_SW, TONE_ON, TONE_HIGH, XMT_CUT;
  logic        BAND_ELIM_FILTER, GUARD, LOOP_SIG, LOOPBACK_RELAY;
  logic        SLEEVE_O, SLEEVE_OE, SLEEVE_LINE;
  int          n_fail = 0, check_count = 0, on_c = 0, hi_c = 0;
  int          on_w = 0, hi_w = 0, n_on = 0, n0;
  sfl_ctrl #(.TICK_CYCLES(TC)) u_dut (.CLK, .RSTN, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .PRDATA, .LOOP_OFFHOOK,
    .SF_TONE_DET, .LB_TONE_DET, .EXT_LOOPBACK_N, .MAN_LOOPBACK_SW,
    .TONE_ON, .TONE_HIGH, .XMT_CUT, .BAND_ELIM_FILTER, .GUARD, .LOOP_SIG,
    .LOOPBACK_RELAY, .SLEEVE_O, .SLEEVE_OE);
  sfl_far u_far (.CLK, .SLEEVE_O, .SLEEVE_OE, .LOOP_OFFHOOK, .SF_TONE_DET,
    .LB_TONE_DET, .EXT_LOOPBACK_N, .MAN_LOOPBACK_SW, .SLEEVE_LINE);
  initial begin
    forever #2.5 CLK = ~CLK;
  end
  // Widths of the last tone burst and high-level span
  always @(posedge CLK) begin
    on_c <= TONE_ON ? on_c + 1 : 0;
    hi_c <= TONE_HIGH ? hi_c + 1 : 0;
    if (TONE_ON && on_c == 0) n_on <= n_on + 1;
    if (!TONE_ON && on_c > 0) on_w <= on_c;
    if (!TONE_HIGH && hi_c > 0) hi_w <= hi_c;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ms(input int m);
    repeat (m * TC) @(posedge CLK);
  endtask : ms
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1);
    chk(n, 1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask : apb
  task automatic finish_test();
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= 1;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(1, 8'h00, 1);
    apb(0, 8'h00, 0);
    chk(rd, 1);
    ms(20);
    apb(1, 8'h04, 32'hffff);
    apb(0, 8'h04, 0);
    chk({err, rd}, 33'h400);
    apb(0, 8'h08, 0);
    chk({err, rd}, {1'b1, 32'h0});
    n0 = n_on;
    u_far.set(0, 1);
    ms(10);
    u_far.set(0, 0);
    ms(50);
    chk(n_on == n0, 1);
    u_far.set(0, 1);
    ms(40);
    u_far.set(0, 0);
    ms(60);
    chk(on_w >= 47 * TC && on_w <= 53 * TC, 1);
    u_far.set(0, 1);
    ms(10);
    chk({XMT_CUT, TONE_ON}, 2'b10);
    ms(90);
    u_far.set(0, 0);
    ms(60);
    chk(on_w >= 97 * TC && on_w <= 103 * TC, 1);
    chk(XMT_CUT, 1);
    ms(120);
    chk({XMT_CUT, SLEEVE_LINE}, 2'b00);
    u_far.set(0, 1);
    ms(300);
    chk({TONE_HIGH, SLEEVE_LINE}, 2'b11);
    ms(300);
    u_far.set(0, 0);
    ms(40);
    chk(hi_w >= 300 * TC && hi_w <= 500 * TC, 1);
    u_far.set(1, 1);
    ms(80);
    chk({GUARD, LOOP_SIG, BAND_ELIM_FILTER}, 3'b111);
    ms(220);
    u_far.set(1, 0);
    ms(40);
    chk({GUARD, LOOP_SIG, BAND_ELIM_FILTER}, 3'b111);
    ms(25);
    chk(BAND_ELIM_FILTER, 0);
    ms(125);
    chk({GUARD, LOOP_SIG}, 2'b11);
    ms(120);
    chk({GUARD, LOOP_SIG}, 2'b00);
    u_far.set(1, 1);
    ms(60);
    u_far.set(1, 0);
    ms(140);
    chk(BAND_ELIM_FILTER, 1);
    ms(80);
    chk(BAND_ELIM_FILTER, 0);
    ms(50);
    u_far.set(2, 1);
    ms(2600);
    chk(LOOPBACK_RELAY, 0);
    ms(100);
    u_far.set(2, 0);
    ms(10);
    apb(0, 8'h04, 0);
    chk(rd[1:0], 2'b11);
    u_far.set(1, 1);
    ms(30);
    chk({TONE_ON, XMT_CUT}, 2'b10);
    u_far.set(1, 0);
    ms(300);
    u_far.set(2, 1);
    ms(850);
    chk(LOOPBACK_RELAY, 1);
    ms(650);
    chk(LOOPBACK_RELAY, 0);
    u_far.set(2, 0);
    ms(10);
    for (int i = 3; i <= 4; i++) begin
      u_far.set(i, 1);
      ms(5);
      apb(0, 8'h04, 0);
      chk(rd[3:0], {i == 4, i == 3, 2'b01});
      u_far.set(i, 0);
      ms(5);
      chk(LOOPBACK_RELAY, 0);
    end
    finish_test();
  end
endmodule : sfl_ctrl_test
